// ### scac_pkg.sv
// Shared constants and carriers for the secure card command handler.
// Assumes the frame layer strips header and checksum on input and appends one on output.
package scac_pkg;

  // ----------------------------------------------------------------
  // Command codes, failure codes and the more-frames status code
  // ----------------------------------------------------------------
  localparam logic [7:0] OPC_AUTH_FULL = 8'h90;
  localparam logic [7:0] OPC_AUTH_STEP1 = 8'h8E;
  localparam logic [7:0] OPC_AUTH_STEP2 = 8'h8F;
  localparam logic [7:0] OPC_FORMAT = 8'h99;
  localparam logic [7:0] OPC_CREATE_APP = 8'h95;
  localparam logic [7:0] OPC_CHANGE_POLICY = 8'h91;
  localparam logic [7:0] FAIL_AUTH_FULL = 8'h6F;
  localparam logic [7:0] FAIL_AUTH_STEP1 = 8'h71;
  localparam logic [7:0] FAIL_AUTH_STEP2 = 8'h70;
  localparam logic [7:0] FAIL_FORMAT = 8'h67;
  localparam logic [7:0] FAIL_CREATE_APP = 8'h6A;
  localparam logic [7:0] FAIL_CHANGE_POLICY = 8'h6E;
  localparam logic [7:0] STATUS_MORE_FRAMES = 8'hAF;

  // ----------------------------------------------------------------
  // Argument and response sizes in bytes
  // ----------------------------------------------------------------
  localparam int ARG_MAX = 17;
  localparam int RSP_MAX = 18;
  localparam int KEY_BYTES = 16;
  localparam int NONCE_BYTES = 8;
  localparam int HALF_NONCE = 4;
  localparam logic [4:0] LEN_AUTH_FULL = 5'd17;
  localparam logic [4:0] LEN_AUTH_STEP1 = 5'd1;
  localparam logic [4:0] LEN_AUTH_STEP2 = 5'd16;
  localparam logic [4:0] LEN_FORMAT = 5'd0;
  localparam logic [4:0] LEN_CREATE_APP = 5'd5;
  localparam logic [4:0] LEN_CHANGE_POLICY = 5'd8;
  localparam logic [4:0] RSP_LEN_FAIL = 5'd1;
  localparam logic [4:0] RSP_LEN_STATUS = 5'd2;
  localparam logic [4:0] RSP_LEN_CHALLENGE = 5'd10;
  localparam logic [4:0] RSP_LEN_KEY = 5'd18;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] opcode;
    logic [4:0] nargs;
    logic [8*ARG_MAX-1:0] args;
  } scac_card_req_s;

  typedef struct packed {
    logic ok;
    logic [7:0] status;
    logic [8*KEY_BYTES-1:0] data;
  } scac_card_ans_s;

endpackage

// ### scac_rsp_tx.sv
// Response byte streamer: shifts out a loaded response, low byte first.
// Assumes the frame layer appends the checksum after the byte marked last.
`timescale 1ns/1ps
module scac_rsp_tx (
  // Clock and reset
  input wire logic clock_in,
  input wire logic resetn_in,
  // Load side
  input wire logic start_in,
  input wire logic [8*scac_pkg::RSP_MAX-1:0] buf_in,
  input wire logic [4:0] len_in,
  output logic done_out,
  // Byte stream side
  output logic rsp_valid_out,
  output logic [7:0] rsp_byte_out,
  output logic rsp_last_out,
  input wire logic rsp_ready_in
);

  logic [8*scac_pkg::RSP_MAX-1:0] shift_q;
  logic [4:0] left_q;
  logic take;

  assign take = rsp_valid_out && rsp_ready_in;
  assign rsp_valid_out = (left_q != 5'd0);
  assign rsp_last_out = (left_q == 5'd1);
  assign rsp_byte_out = shift_q[7:0];
  assign done_out = take && rsp_last_out;

  // ----------------------------------------------------------------
  // Shift register and byte count
  // ----------------------------------------------------------------
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      shift_q <= '0;
      left_q <= 5'd0;
    end else if (start_in) begin
      shift_q <= buf_in;
      left_q <= len_in;
    end else if (take) begin
      shift_q <= {8'h00, shift_q[8*scac_pkg::RSP_MAX-1:8]};
      left_q <= left_q - 5'd1;
    end
  end

endmodule // scac_rsp_tx

// ### scac_cmd_handler.sv
// Command handler for card authentication and initialisation commands.
// Assumes a frame layer delivers command bytes (opcode first) with a last flag,
// a card engine performs the radio exchange and cryptography, and the frame
// layer appends the checksum after the last response byte.
// Operation
// RULE1: Authenticate takes key slot and 16-byte key.
// RULE2: Success sends session key; failure sends 0x6F.
// RULE3: Status only means card exchange succeeded.
// RULE4: Step one returns status and 8-byte challenge.
// RULE5: Host must follow step one with step two.
// RULE6: Step two returns status and encrypted nonce.
// RULE7: Host verifies decrypted rotated nonce itself.
// RULE8: Session key interleaves host and card nonces.
// RULE9: Format deletes applications; failure sends 0x67.
// RULE10: Create application takes identifier, policy, count.
// RULE11: Change key policy takes 8 encrypted bytes.
// RULE12: Success echoes code; failure only failure code.
`timescale 1ns/1ps
module scac_cmd_handler (
  // Clock and reset
  input wire logic clock_in,
  input wire logic resetn_in,
  // Command bytes from the frame layer
  input wire logic cmd_valid_in,
  input wire logic [7:0] cmd_byte_in,
  input wire logic cmd_last_in,
  output logic cmd_ready_out,
  // Card engine request
  output logic card_req_valid_out,
  output scac_pkg::scac_card_req_s card_req_out,
  input wire logic card_req_ready_in,
  // Card engine answer
  input wire logic card_done_in,
  input wire scac_pkg::scac_card_ans_s card_ans_in,
  // Response bytes to the frame layer
  output logic rsp_valid_out,
  output logic [7:0] rsp_byte_out,
  output logic rsp_last_out,
  input wire logic rsp_ready_in,
  // Session state
  output logic [8*scac_pkg::KEY_BYTES-1:0] derived_link_key_out,
  output logic link_key_valid_out,
  output logic step2_pending_out
);

  typedef enum logic [2:0] {
    ST_OPCODE,
    ST_ARGS,
    ST_CHECK,
    ST_CARD_REQ,
    ST_CARD_WAIT,
    ST_RESP
  } scac_state_e;

  scac_state_e state_q;
  logic [7:0] opcode_q;
  logic [7:0] args_q [scac_pkg::ARG_MAX];
  logic [4:0] nargs_q;
  logic overflow_q;
  logic pending_q;
  logic [8*scac_pkg::RSP_MAX-1:0] rsp_buf_q;
  logic [4:0] rsp_len_q;
  logic tx_start_q;
  logic tx_done;
  logic [8*scac_pkg::KEY_BYTES-1:0] key_q;
  logic key_valid_q;
  logic [8*scac_pkg::KEY_BYTES-1:0] key_d;
  logic known;
  logic [4:0] want_len;
  logic [7:0] fail_code;
  logic [8*scac_pkg::RSP_MAX-1:0] rsp_d;
  logic [4:0] rsp_len_d;
  logic cmd_take;

  assign cmd_take = cmd_valid_in && cmd_ready_out;
  assign cmd_ready_out = (state_q == ST_OPCODE) || (state_q == ST_ARGS);
  assign card_req_valid_out = (state_q == ST_CARD_REQ);
  assign derived_link_key_out = key_q;
  assign link_key_valid_out = key_valid_q;
  assign step2_pending_out = pending_q;

  // ----------------------------------------------------------------
  // Per-command argument length and failure code
  // ----------------------------------------------------------------
  always_comb begin
    known = 1'b1;
    want_len = scac_pkg::LEN_FORMAT;
    fail_code = scac_pkg::FAIL_FORMAT;
    case (opcode_q)
      scac_pkg::OPC_AUTH_FULL: begin
        want_len = scac_pkg::LEN_AUTH_FULL; // RULE1
        fail_code = scac_pkg::FAIL_AUTH_FULL; // RULE2
      end
      scac_pkg::OPC_AUTH_STEP1: begin
        want_len = scac_pkg::LEN_AUTH_STEP1; // RULE4
        fail_code = scac_pkg::FAIL_AUTH_STEP1; // RULE4
      end
      scac_pkg::OPC_AUTH_STEP2: begin
        want_len = scac_pkg::LEN_AUTH_STEP2; // RULE6
        fail_code = scac_pkg::FAIL_AUTH_STEP2; // RULE6
      end
      scac_pkg::OPC_FORMAT: begin
        want_len = scac_pkg::LEN_FORMAT; // RULE9
        fail_code = scac_pkg::FAIL_FORMAT; // RULE9
      end
      scac_pkg::OPC_CREATE_APP: begin
        want_len = scac_pkg::LEN_CREATE_APP; // RULE10
        fail_code = scac_pkg::FAIL_CREATE_APP; // RULE10
      end
      scac_pkg::OPC_CHANGE_POLICY: begin
        want_len = scac_pkg::LEN_CHANGE_POLICY; // RULE11
        fail_code = scac_pkg::FAIL_CHANGE_POLICY; // RULE11
      end
      default: begin
        known = 1'b0;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Session key from host nonce (bytes 0..7) and card nonce (8..15)
  // ----------------------------------------------------------------
  for (genvar g = 0; g < scac_pkg::HALF_NONCE; g++) begin : g_key
    assign key_d[8*g +: 8] = card_ans_in.data[8*g +: 8]; // RULE8
    assign key_d[8*(g+scac_pkg::HALF_NONCE) +: 8] =
      card_ans_in.data[8*(g+scac_pkg::NONCE_BYTES) +: 8]; // RULE8
    assign key_d[8*(g+2*scac_pkg::HALF_NONCE) +: 8] =
      card_ans_in.data[8*(g+scac_pkg::HALF_NONCE) +: 8]; // RULE8
    assign key_d[8*(g+3*scac_pkg::HALF_NONCE) +: 8] =
      card_ans_in.data[8*(g+scac_pkg::NONCE_BYTES+scac_pkg::HALF_NONCE) +: 8]; // RULE8
  end

  // ----------------------------------------------------------------
  // Response built from the card answer
  // ----------------------------------------------------------------
  always_comb begin
    rsp_d = '0;
    rsp_len_d = scac_pkg::RSP_LEN_FAIL;
    if (!card_ans_in.ok) begin
      rsp_d[7:0] = fail_code; // RULE12
    end else begin
      rsp_d[7:0] = opcode_q; // RULE12
      rsp_d[15:8] = card_ans_in.status; // RULE3
      rsp_len_d = scac_pkg::RSP_LEN_STATUS;
      case (opcode_q)
        scac_pkg::OPC_AUTH_FULL: begin
          rsp_d[8*scac_pkg::RSP_MAX-1:16] = key_d; // RULE2
          rsp_len_d = scac_pkg::RSP_LEN_KEY;
        end
        scac_pkg::OPC_AUTH_STEP1: begin
          rsp_d[16 +: 8*scac_pkg::NONCE_BYTES] =
            card_ans_in.data[8*scac_pkg::NONCE_BYTES-1:0]; // RULE4
          rsp_len_d = scac_pkg::RSP_LEN_CHALLENGE;
        end
        scac_pkg::OPC_AUTH_STEP2: begin
          rsp_d[8*scac_pkg::RSP_MAX-1:16] = card_ans_in.data; // RULE6
          rsp_len_d = scac_pkg::RSP_LEN_KEY;
        end
        default: begin
          rsp_len_d = scac_pkg::RSP_LEN_STATUS;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Command sequencing
  // ----------------------------------------------------------------
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state_q <= ST_OPCODE;
      opcode_q <= 8'h00;
      nargs_q <= 5'd0;
      overflow_q <= 1'b0;
      tx_start_q <= 1'b0;
    end else begin
      tx_start_q <= 1'b0;
      case (state_q)
        ST_OPCODE: begin
          if (cmd_take) begin
            opcode_q <= cmd_byte_in;
            nargs_q <= 5'd0;
            overflow_q <= 1'b0;
            state_q <= cmd_last_in ? ST_CHECK : ST_ARGS;
          end
        end
        ST_ARGS: begin
          if (cmd_take) begin
            if (nargs_q == 5'(scac_pkg::ARG_MAX)) begin
              overflow_q <= 1'b1;
            end else begin
              nargs_q <= nargs_q + 5'd1;
            end
            if (cmd_last_in) begin
              state_q <= ST_CHECK;
            end
          end
        end
        ST_CHECK: begin
          if (!known) begin
            state_q <= ST_OPCODE;
          end else if (overflow_q || nargs_q != want_len ||
                       (opcode_q == scac_pkg::OPC_AUTH_STEP2 && !pending_q)) begin
            state_q <= ST_RESP; // RULE5
            tx_start_q <= 1'b1;
          end else begin
            state_q <= ST_CARD_REQ; // RULE9
          end
        end
        ST_CARD_REQ: begin
          if (card_req_ready_in) begin
            state_q <= ST_CARD_WAIT;
          end
        end
        ST_CARD_WAIT: begin
          if (card_done_in) begin
            state_q <= ST_RESP;
            tx_start_q <= 1'b1;
          end
        end
        ST_RESP: begin
          if (tx_done) begin
            state_q <= ST_OPCODE;
          end
        end
        default: begin
          state_q <= ST_OPCODE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Argument storage
  // ----------------------------------------------------------------
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      for (int i = 0; i < scac_pkg::ARG_MAX; i++) begin
        args_q[i] <= 8'h00;
      end
    end else if (state_q == ST_ARGS && cmd_take && nargs_q != 5'(scac_pkg::ARG_MAX)) begin
      args_q[nargs_q] <= cmd_byte_in;
    end
  end

  for (genvar a = 0; a < scac_pkg::ARG_MAX; a++) begin : g_req
    assign card_req_out.args[8*a +: 8] = args_q[a]; // RULE10
  end
  assign card_req_out.opcode = opcode_q;
  assign card_req_out.nargs = nargs_q;

  // ----------------------------------------------------------------
  // Response buffer, local failures carry only the failure code
  // ----------------------------------------------------------------
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rsp_buf_q <= '0;
      rsp_len_q <= 5'd0;
    end else if (state_q == ST_CHECK) begin
      rsp_buf_q <= {{(8*scac_pkg::RSP_MAX-8){1'b0}}, fail_code}; // RULE12
      rsp_len_q <= scac_pkg::RSP_LEN_FAIL;
    end else if (state_q == ST_CARD_WAIT && card_done_in) begin
      rsp_buf_q <= rsp_d;
      rsp_len_q <= rsp_len_d;
    end
  end

  // ----------------------------------------------------------------
  // Two-step authentication and session key state
  // ----------------------------------------------------------------
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      pending_q <= 1'b0;
      key_q <= '0;
      key_valid_q <= 1'b0;
    end else begin
      if (state_q == ST_CHECK && known) begin
        pending_q <= 1'b0; // RULE5
      end
      if (state_q == ST_CARD_WAIT && card_done_in && card_ans_in.ok) begin
        if (opcode_q == scac_pkg::OPC_AUTH_STEP1 &&
            card_ans_in.status == scac_pkg::STATUS_MORE_FRAMES) begin
          pending_q <= 1'b1; // RULE5
        end
        if (opcode_q == scac_pkg::OPC_AUTH_FULL) begin
          key_q <= key_d; // RULE8
          key_valid_q <= 1'b1;
        end
      end
    end
  end

  scac_rsp_tx u_tx (
    .clock_in(clock_in),
    .resetn_in(resetn_in),
    .start_in(tx_start_q),
    .buf_in(rsp_buf_q),
    .len_in(rsp_len_q),
    .done_out(tx_done),
    .rsp_valid_out(rsp_valid_out),
    .rsp_byte_out(rsp_byte_out),
    .rsp_last_out(rsp_last_out),
    .rsp_ready_in(rsp_ready_in)
  );

endmodule // scac_cmd_handler

// ### scac_card_model.sv
// Card engine model that answers the handler's card requests.
// Assumes the bench sets the answer fields before each request.
`timescale 1ns/1ps
module scac_card_model (
  // Clock and reset
  input wire logic clock_in,
  input wire logic resetn_in,
  // Request and answer
  input wire logic req_valid_in,
  output logic req_ready_out,
  output logic done_out,
  output scac_pkg::scac_card_ans_s ans_out,
  // Bench control
  input wire logic ok_in,
  input wire logic [7:0] status_in,
  input wire logic [127:0] data_in,
  input wire logic [3:0] delay_in
);
  logic busy_q;
  logic [3:0] cnt_q;
  assign req_ready_out = !busy_q;
  // Answer shows only in the done cycle; otherwise the inverse.
  assign ans_out = done_out ? {ok_in, status_in, data_in} : ~{ok_in, status_in, data_in};
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      busy_q <= 1'b0;
      cnt_q <= 4'h0;
      done_out <= 1'b0;
    end else begin
      done_out <= 1'b0;
      if (req_valid_in && req_ready_out) begin
        busy_q <= 1'b1;
        cnt_q <= delay_in;
      end else if (busy_q && cnt_q == 4'h0) begin
        busy_q <= 1'b0;
        done_out <= 1'b1;
      end else if (busy_q) begin
        cnt_q <= cnt_q - 4'h1;
      end
    end
  end
endmodule // scac_card_model

// ### scac_cmd_handler_checker.sv
// Port checker for the command handler.
// Assumes it is bound to scac_cmd_handler and sees only its ports.
`timescale 1ns/1ps
module scac_cmd_handler_checker (
  // Clock and reset
  input wire logic clock_in,
  input wire logic resetn_in,
  // Command side
  input wire logic cmd_valid_in,
  input wire logic [7:0] cmd_byte_in,
  input wire logic cmd_last_in,
  input wire logic cmd_ready_out,
  // Card side
  input wire logic card_req_valid_out,
  input wire scac_pkg::scac_card_req_s card_req_out,
  input wire logic card_req_ready_in,
  input wire logic card_done_in,
  input wire scac_pkg::scac_card_ans_s card_ans_in,
  // Response side
  input wire logic rsp_valid_out,
  input wire logic [7:0] rsp_byte_out,
  input wire logic rsp_last_out,
  input wire logic rsp_ready_in,
  // Session side
  input wire logic [8*scac_pkg::KEY_BYTES-1:0] derived_link_key_out,
  input wire logic link_key_valid_out,
  input wire logic step2_pending_out
);
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  logic [7:0] stat_q;
  logic [4:0] cnt_q;
  logic take;
  logic [7:0] op;
  logic [127:0] d;
  assign take = rsp_valid_out && rsp_ready_in;
  assign op = card_req_out.opcode;
  assign d = card_ans_in.data;
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      stat_q <= 8'h00;
    end else if (card_done_in) begin
      stat_q <= card_ans_in.status;
    end
  end
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      cnt_q <= 5'h00;
    end else if (take) begin
      cnt_q <= rsp_last_out ? 5'h00 : cnt_q + 5'h01;
    end
  end
  function automatic logic [7:0] fail_of(input logic [7:0] c);
    case (c)
      8'h90: fail_of = 8'h6F;
      8'h8E: fail_of = 8'h71;
      8'h8F: fail_of = 8'h70;
      8'h99: fail_of = 8'h67;
      8'h95: fail_of = 8'h6A;
      default: fail_of = 8'h6E;
    endcase
  endfunction
  default clocking @(posedge clock_in); endclocking
  default disable iff (!resetn_in);
  AST_REQ_HOLD: assert property (card_req_valid_out && !card_req_ready_in |=>
    card_req_valid_out && $stable(card_req_out)) else $error("card request dropped or changed");
  AST_ONE_REQ: assert property (card_req_valid_out && card_req_ready_in |=>
    !card_req_valid_out [*3]) else $error("second card request too soon");
  AST_ECHO: assert property (card_done_in && card_ans_in.ok |-> ##2
    rsp_valid_out && !rsp_last_out && rsp_byte_out == op) else $error("opcode not echoed");
  AST_CARD_FAIL: assert property (card_done_in && !card_ans_in.ok |-> ##2
    rsp_valid_out && rsp_last_out && rsp_byte_out == fail_of(op)) else $error("bad fail code");
  AST_STATUS: assert property (take && cnt_q == 5'h00 && !rsp_last_out |=>
    rsp_valid_out && rsp_byte_out == stat_q) else $error("status byte wrong");
  AST_RSP_LEN: assert property (take && rsp_last_out && cnt_q != 5'h00 |->
    cnt_q + 5'h01 == ((op == 8'h90 || op == 8'h8F) ? 5'h12 : (op == 8'h8E) ? 5'h0A : 5'h02))
    else $error("response length wrong");
  AST_RSP_HOLD: assert property (rsp_valid_out && !rsp_ready_in |=> rsp_valid_out &&
    $stable(rsp_byte_out) && $stable(rsp_last_out)) else $error("response byte not held");
  AST_KEY: assert property (card_done_in && card_ans_in.ok && op == 8'h90 |=>
    link_key_valid_out && derived_link_key_out == {$past(d[127:96]), $past(d[63:32]),
    $past(d[95:64]), $past(d[31:0])}) else $error("session key wrong");
  AST_PENDING: assert property (card_done_in && card_ans_in.ok && op == 8'h8E &&
    card_ans_in.status == 8'hAF |=> step2_pending_out) else $error("step two not pending");
  AST_BUSY: assert property (rsp_valid_out |-> !cmd_ready_out)
    else $error("command taken during response");
  COV_KEY: cover property (card_done_in && card_ans_in.ok && op == 8'h90);
  COV_PEND: cover property ($rose(step2_pending_out));
  COV_FAIL: cover property (take && rsp_last_out && cnt_q == 5'h00);
endmodule // scac_cmd_handler_checker
bind scac_cmd_handler scac_cmd_handler_checker i_chk (
  .clock_in(clock_in), .resetn_in(resetn_in), .cmd_valid_in(cmd_valid_in),
  .cmd_byte_in(cmd_byte_in), .cmd_last_in(cmd_last_in), .cmd_ready_out(cmd_ready_out),
  .card_req_valid_out(card_req_valid_out), .card_req_out(card_req_out),
  .card_req_ready_in(card_req_ready_in), .card_done_in(card_done_in),
  .card_ans_in(card_ans_in), .rsp_valid_out(rsp_valid_out), .rsp_byte_out(rsp_byte_out),
  .rsp_last_out(rsp_last_out), .rsp_ready_in(rsp_ready_in),
  .derived_link_key_out(derived_link_key_out), .link_key_valid_out(link_key_valid_out),
  .step2_pending_out(step2_pending_out));

// ### scac_cmd_handler_tb.sv
// Self-checking bench for the command handler with a card engine model.
// Assumes the package, handler, checker and card model are compiled first.
`timescale 1ns/1ps
module scac_cmd_handler_tb;
  logic clock_in = 1'b0;
  logic resetn_in = 1'b0;
  logic cmd_valid_in = 1'b0;
  logic [7:0] cmd_byte_in = 8'h00;
  logic cmd_last_in = 1'b0;
  logic rsp_ready_in = 1'b1;
  logic cmd_ready_out, card_req_valid_out, card_req_ready_in, card_done_in;
  logic rsp_valid_out, rsp_last_out, link_key_valid_out, step2_pending_out;
  logic [7:0] rsp_byte_out;
  logic [127:0] derived_link_key_out;
  scac_pkg::scac_card_req_s card_req_out;
  scac_pkg::scac_card_ans_s card_ans_in;
  logic eng_ok = 1'b1;
  logic [7:0] eng_st = 8'h00;
  logic [127:0] eng_data = 128'h0;
  logic [3:0] eng_dly = 4'h0;
  logic [31:0] lfsr = 32'h9018;
  logic [8:0] exp_q[$];
  logic pend = 1'b0;
  logic [7:0] t_op [17] = '{8'h90, 8'h90, 8'h8F, 8'h8E, 8'h8F, 8'h99, 8'h99, 8'h95, 8'h91,
    8'h95, 8'h8E, 8'h91, 8'h8E, 8'h99, 8'h8F, 8'h8E, 8'h8F};
  logic [16:0] t_ok = 17'h0F3BD;
  logic [16:0] t_bad = 17'h00200;
  int n_fail = 0;
  int check_count = 0;
  int cyc = 0;
  always #25 clock_in = ~clock_in;
  scac_cmd_handler i_dut (.clock_in(clock_in), .resetn_in(resetn_in),
    .cmd_valid_in(cmd_valid_in), .cmd_byte_in(cmd_byte_in), .cmd_last_in(cmd_last_in),
    .cmd_ready_out(cmd_ready_out), .card_req_valid_out(card_req_valid_out),
    .card_req_out(card_req_out), .card_req_ready_in(card_req_ready_in),
    .card_done_in(card_done_in), .card_ans_in(card_ans_in), .rsp_valid_out(rsp_valid_out),
    .rsp_byte_out(rsp_byte_out), .rsp_last_out(rsp_last_out), .rsp_ready_in(rsp_ready_in),
    .derived_link_key_out(derived_link_key_out), .link_key_valid_out(link_key_valid_out),
    .step2_pending_out(step2_pending_out));
  scac_card_model i_card (.clock_in(clock_in), .resetn_in(resetn_in),
    .req_valid_in(card_req_valid_out), .req_ready_out(card_req_ready_in),
    .done_out(card_done_in), .ans_out(card_ans_in), .ok_in(eng_ok), .status_in(eng_st),
    .data_in(eng_data), .delay_in(eng_dly));
  function automatic logic [31:0] nxt(input logic [31:0] s);
    nxt = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Argument count, failure code and payload length of each command.
  function automatic logic [23:0] info(input logic [7:0] op);
    case (op)
      8'h90: info = {8'h11, 8'h6F, 8'h10};
      8'h8E: info = {8'h01, 8'h71, 8'h08};
      8'h8F: info = {8'h10, 8'h70, 8'h10};
      8'h99: info = {8'h00, 8'h67, 8'h00};
      8'h95: info = {8'h05, 8'h6A, 8'h00};
      default: info = {8'h08, 8'h6E, 8'h00};
    endcase
  endfunction
  task automatic check(input logic [127:0] seen, input logic [127:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Stimulus and scoreboard
  // ----------------------------------------------------------------
  always @(posedge clock_in) begin
    #2;
    cyc++;
    rsp_ready_in = (cyc % 3) != 0;
  end
  always @(posedge clock_in) begin
    if (rsp_valid_out === 1'b1 && rsp_ready_in === 1'b1) begin
      check({rsp_last_out, rsp_byte_out}, exp_q.size() > 0 ? exp_q.pop_front() : 9'h1FF);
    end
  end
  task automatic run_cmd(input logic [7:0] op, input logic bad, input logic eok);
    logic [23:0] inf;
    logic [127:0] ek;
    logic [127:0] pl;
    logic [135:0] sa;
    logic loc;
    int k;
    int w;
    inf = info(op);
    loc = bad || (op == 8'h8F && !pend);
    eng_ok = eok;
    eng_st = (op == 8'h8E) ? 8'hAF : lfsr[15:8];
    for (k = 0; k < 4; k++) begin
      lfsr = nxt(lfsr);
      eng_data[32*k+:32] = lfsr;
    end
    eng_dly = lfsr[3:0];
    for (k = 0; k < 16; k++) begin
      ek[8*k+:8] = eng_data[8*(k/4 == 1 ? k + 4 : k/4 == 2 ? k - 4 : k)+:8];
    end
    pl = (op == 8'h90) ? ek : eng_data;
    if (loc || !eok) begin
      exp_q.push_back({1'b1, inf[15:8]});
    end else begin
      exp_q.push_back({1'b0, op});
      exp_q.push_back({inf[7:0] == 8'h00, eng_st});
      for (k = 0; k < int'(inf[7:0]); k++) begin
        exp_q.push_back({k == int'(inf[7:0]) - 1, pl[8*k+:8]});
      end
    end
    for (k = 0; k <= int'(inf[23:16]) - int'(bad); k++) begin
      cmd_valid_in = 1'b1;
      cmd_byte_in = (k == 0) ? op : lfsr[7:0];
      cmd_last_in = (k == int'(inf[23:16]) - int'(bad));
      if (k > 0) begin
        sa[8*(k-1)+:8] = lfsr[7:0];
      end
      lfsr = nxt(lfsr);
      w = 0;
      do begin
        @(posedge clock_in);
        w++;
      end while (cmd_ready_out !== 1'b1 && w < 100);
      #2;
    end
    cmd_valid_in = 1'b0;
    cmd_last_in = 1'b0;
    for (w = 0; w < 400 && (exp_q.size() != 0 || rsp_valid_out !== 1'b0); w++) begin
      @(posedge clock_in);
    end
    repeat (2) @(posedge clock_in);
    #2;
    pend = (op == 8'h8E) && !loc && eok;
    check(step2_pending_out, pend);
    check(128'(exp_q.size()), 128'h0);
    check(card_req_out.opcode, op);
    check(card_req_out.nargs, inf[20:16] - 5'(bad));
    for (k = 0; k < int'(inf[20:16]) - int'(bad); k++) begin
      check(card_req_out.args[8*k+:8], sa[8*k+:8]);
    end
    if (op == 8'h90 && eok) begin
      check(derived_link_key_out, ek);
      check(link_key_valid_out, 1'b1);
    end
  endtask
  initial begin
    repeat (12) @(posedge clock_in);
    #2;
    resetn_in = 1'b1;
    for (int i = 0; i < 17; i++) begin
      run_cmd(t_op[i], t_bad[i], t_ok[i]);
      $display("test %0d command %h done", i, t_op[i]);
    end
    // An unknown opcode is dropped with no response.
    cmd_valid_in = 1'b1;
    cmd_byte_in = 8'h92;
    cmd_last_in = 1'b1;
    @(posedge clock_in);
    #2;
    cmd_valid_in = 1'b0;
    cmd_last_in = 1'b0;
    repeat (8) @(posedge clock_in);
    #2;
    check(cmd_ready_out, 1'b1);
    check(128'(exp_q.size()), 128'h0);
    check(step2_pending_out, pend);
    $display("test unknown command done");
    complete_run();
  end
  initial begin
    #1000000;
    n_fail++;
    complete_run();
  end
endmodule // scac_cmd_handler_tb
